// >>> wwrs_pkg.sv
// Contract
// - window check flags slow and fast clears
// - software enables fast-pulse detection
// - select pin disables watchdog, secondary held low
// - register chooses latching resets on error
// - five watchdog resets latch, clear zeroes count
// - ten consecutive fast pulses cause reset
// - timing counter zeroed on listed events
// - reset counter stops at five
// - first clear within 256 ms start wait
// - five start resets without clear latch off
// - disabled watchdog skips start wait
// - secondary released after clear in normal time
// - power-on timer releases primary reset
// - regulator drop pulls both resets low
// - primary low lasts full power-on delay
// - reset pin mismatch forces resets, diag low
// - oscillator fault latches supplies, resets, diag
// - any fault latches diag and records it
// - diag pin mismatch latches diag low
// - diag high after faults normal and cleared
// - all logic on one internal clock
package wwrs_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned TICK_W = 18;
  localparam int unsigned START_WAIT_MS = 256;
  localparam logic [15:0] START_WAIT_TICKS = 16'(START_WAIT_MS * 1000 / TICK_PERIOD_US);
  localparam logic [2:0] RST_COUNT_LIMIT = 3'h5;
  localparam logic [3:0] FAST_COUNT_LIMIT = 4'ha;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_WINDOW = 4'h4;
  localparam logic [3:0] OFF_FAULT = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  localparam int unsigned CTRL_FAST_EN = 0;
  localparam int unsigned CTRL_LATCH_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int unsigned WIN_SLOW_LSB = 0;
  localparam int unsigned WIN_FAST_LSB = 8;
  localparam int unsigned WIN_NORMAL_LSB = 16;
  localparam int unsigned WIN_POR_LSB = 24;
  localparam logic [31:0] WINDOW_RST = 32'h0a640564;
  localparam int unsigned FLT_SLOW = 0;
  localparam int unsigned FLT_FAST = 1;
  localparam int unsigned FLT_START = 2;
  localparam int unsigned FLT_RST_MIS = 3;
  localparam int unsigned FLT_DIAG_MIS = 4;
  localparam int unsigned FLT_OSC = 5;
  localparam int unsigned FLT_REG_LOW = 6;
  localparam int unsigned FLT_COUNT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_POR, ST_OFF, ST_START, ST_NWAIT, ST_RUN, ST_WDRST, ST_LATCH}
    wwrs_state_t;
endpackage : wwrs_pkg

// >>> wwrs_pulse_sync.sv
`timescale 1ns/10ps
`default_nettype none
module wwrs_pulse_sync
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pulse_in,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pulse_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edge taken from the second stage only
  assign rise = sync_reg & ~last_reg;
endmodule : wwrs_pulse_sync
`default_nettype wire

// >>> wwrs_supervisor.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module wwrs_supervisor
  import wwrs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic watchdog_clear_pulse_in,
  input wire logic watchdog_select_pin,
  input wire logic main_regulator_ok,
  input wire logic osc_freq_fault,
  input wire logic primary_reset_sense,
  input wire logic secondary_reset_sense,
  input wire logic diag_sense,
  output logic primary_reset_n,
  output logic secondary_reset_n,
  output logic diag_fault_n,
  output logic supplies_off,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic [3:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] window_reg;
  logic [7:0] fault_reg;
  logic [7:0] fault_next;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_ctrl = do_write & (waddr_reg == OFF_CTRL);
  wire wr_window = do_write & (waddr_reg == OFF_WINDOW);
  wire wr_fault = do_write & (waddr_reg == OFF_FAULT);
  wire wr_known = wr_ctrl | wr_window | wr_fault | (waddr_reg == OFF_STATUS);
  wire [31:0] ctrl_merged = merge_bytes({30'h0, ctrl_reg}, wdata_reg, wstrb_reg);
  wire [31:0] fault_w1c = merge_bytes(32'h0, wdata_reg, wstrb_reg);
  wire fast_en = ctrl_reg[CTRL_FAST_EN];
  wire latch_en = ctrl_reg[CTRL_LATCH_EN];
  wire [15:0] slow_ticks = {8'h0, window_reg[WIN_SLOW_LSB +: 8]};
  wire [15:0] fast_ticks = {8'h0, window_reg[WIN_FAST_LSB +: 8]};
  wire [15:0] normal_ticks = {8'h0, window_reg[WIN_NORMAL_LSB +: 8]};
  wire [15:0] por_ticks = {8'h0, window_reg[WIN_POR_LSB +: 8]};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RST;
      window_reg <= WINDOW_RST;
    end
    else
    begin
      if (aw_hs)
      begin
        waddr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (b_hs)
      begin
        s_axi_awready <= 1'b1;
      end
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (b_hs)
      begin
        s_axi_wready <= 1'b1;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_hs)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl)
      begin
        ctrl_reg <= ctrl_merged[1:0];
      end
      if (wr_window)
      begin
        window_reg <= merge_bytes(window_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and clear-pulse edge
  logic [TICK_W-1:0] div_reg;
  logic clear_edge;
  wire tick = (div_reg == TICK_W'(TICK_CYCLES - 1));

  // everything runs from this one clock, slower rates are enables
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= tick ? '0 : div_reg + 1'b1;
    end
  end

  wwrs_pulse_sync wwrs_pulse_sync_inst
  (
    .clock(clock),
    .rst_n(rst_n),
    .pulse_in(watchdog_clear_pulse_in),
    .rise(clear_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and reset sequencing
  wwrs_state_t state_reg;
  wwrs_state_t state_next;
  logic [15:0] timer_reg;
  logic [15:0] timer_next;
  logic [2:0] rst_cnt_reg;
  logic [2:0] rst_cnt_next;
  logic [3:0] fast_cnt_reg;
  logic [3:0] fast_cnt_next;
  logic wd_event;
  logic ev_slow;
  logic ev_fast;
  logic ev_start;
  logic valid_clear;
  logic prim_prev_reg;
  logic sec_prev_reg;
  logic diag_prev_reg;

  wire sel_off = watchdog_select_pin;
  wire watched = (state_reg == ST_START) | (state_reg == ST_NWAIT) | (state_reg == ST_RUN) |
                 (state_reg == ST_WDRST);

  always_comb
  begin
    state_next = state_reg;
    rst_cnt_next = rst_cnt_reg;
    fast_cnt_next = fast_cnt_reg;
    wd_event = 1'b0;
    ev_slow = 1'b0;
    ev_fast = 1'b0;
    ev_start = 1'b0;
    valid_clear = 1'b0;
    case (state_reg)
      ST_POR:
      begin
        // timer restarts on each drop, so a quick recovery still waits out the delay
        if (timer_reg >= por_ticks)
        begin
          state_next = sel_off ? ST_OFF : ST_START;
        end
      end
      ST_OFF:
      begin
        if (!sel_off)
        begin
          state_next = ST_START;
        end
      end
      ST_START:
      begin
        if (clear_edge)
        begin
          valid_clear = 1'b1;
          state_next = ST_NWAIT;
        end
        else if (timer_reg >= START_WAIT_TICKS)
        begin
          ev_start = 1'b1;
          wd_event = 1'b1;
        end
      end
      ST_NWAIT:
      begin
        if (clear_edge)
        begin
          valid_clear = 1'b1;
          state_next = ST_RUN;
        end
        else if (timer_reg >= normal_ticks)
        begin
          ev_slow = 1'b1;
          wd_event = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (clear_edge && fast_en && timer_reg < fast_ticks)
        begin
          fast_cnt_next = fast_cnt_reg + 1'b1;
          if (fast_cnt_next == FAST_COUNT_LIMIT)
          begin
            ev_fast = 1'b1;
            wd_event = 1'b1;
          end
        end
        else if (clear_edge)
        begin
          valid_clear = 1'b1;
        end
        else if (timer_reg >= slow_ticks)
        begin
          ev_slow = 1'b1;
          wd_event = 1'b1;
        end
      end
      ST_WDRST:
      begin
        if (timer_reg >= por_ticks)
        begin
          state_next = ST_START;
        end
      end
      default:
      begin
        state_next = ST_LATCH;
      end
    endcase
    if (valid_clear)
    begin
      rst_cnt_next = 3'h0;
      fast_cnt_next = 4'h0;
    end
    if (wd_event)
    begin
      fast_cnt_next = 4'h0;
      if (rst_cnt_reg != RST_COUNT_LIMIT)
      begin
        rst_cnt_next = rst_cnt_reg + 1'b1;
      end
      // start-wait timeouts count here too, so five in a row latch off
      if (rst_cnt_next == RST_COUNT_LIMIT || latch_en)
      begin
        state_next = ST_LATCH;
      end
      else
      begin
        state_next = ST_WDRST;
      end
    end
    if (osc_freq_fault)
    begin
      state_next = ST_LATCH;
    end
    else if (!main_regulator_ok && state_reg != ST_LATCH)
    begin
      state_next = ST_POR;
    end
    else if (sel_off && watched)
    begin
      state_next = ST_OFF;
      rst_cnt_next = 3'h0;
      fast_cnt_next = 4'h0;
    end
  end

  // clears only restart the timer in ST_START, ST_NWAIT and ST_RUN, so a busy processor cannot stretch a reset
  wire clear_seen = clear_edge & ((state_reg == ST_START) | (state_reg == ST_NWAIT) |
                                  (state_reg == ST_RUN));
  // a long regulator dip holds the delay timer at zero until the supply is back
  wire timer_clr = (state_next != state_reg) | clear_seen | wd_event |
                   (state_reg == ST_OFF) | ~main_regulator_ok;
  assign timer_next = timer_clr ? 16'h0 :
                      (tick && timer_reg != 16'hffff) ? timer_reg + 1'b1 : timer_reg;

  ////////////////////////////////////////////////////////////////////////////
  // error logic and pin read-back
  wire rst_mis = (primary_reset_n == prim_prev_reg && primary_reset_sense != primary_reset_n) |
                 (secondary_reset_n == sec_prev_reg &&
                  secondary_reset_sense != secondary_reset_n);
  wire diag_mis = (diag_fault_n == diag_prev_reg) & (diag_sense != diag_fault_n);
  wire count_latch = wd_event & (rst_cnt_next == RST_COUNT_LIMIT);

  logic [7:0] fault_set;
  always_comb
  begin
    fault_set = 8'h0;
    fault_set[FLT_SLOW] = ev_slow;
    fault_set[FLT_FAST] = ev_fast;
    fault_set[FLT_START] = ev_start;
    fault_set[FLT_RST_MIS] = rst_mis;
    fault_set[FLT_DIAG_MIS] = diag_mis;
    fault_set[FLT_OSC] = osc_freq_fault;
    fault_set[FLT_REG_LOW] = ~main_regulator_ok;
    fault_set[FLT_COUNT] = count_latch;
  end

  // a fault in the clearing cycle survives the write
  assign fault_next = (fault_reg & ~(wr_fault ? fault_w1c[7:0] : 8'h0)) | fault_set;

  wire prim_next = (state_next != ST_POR) & (state_next != ST_WDRST) &
                   (state_next != ST_LATCH) & ~fault_next[FLT_RST_MIS];
  wire sec_next = prim_next & (state_next == ST_RUN);
  wire diag_next = ~|fault_next & ~osc_freq_fault & main_regulator_ok;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_POR;
      timer_reg <= 16'h0;
      rst_cnt_reg <= 3'h0;
      fast_cnt_reg <= 4'h0;
      fault_reg <= 8'h0;
      primary_reset_n <= 1'b0;
      secondary_reset_n <= 1'b0;
      diag_fault_n <= 1'b0;
      supplies_off <= 1'b0;
      prim_prev_reg <= 1'b0;
      sec_prev_reg <= 1'b0;
      diag_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      rst_cnt_reg <= rst_cnt_next;
      fast_cnt_reg <= fast_cnt_next;
      fault_reg <= fault_next;
      primary_reset_n <= prim_next;
      secondary_reset_n <= sec_next;
      diag_fault_n <= diag_next;
      supplies_off <= supplies_off | osc_freq_fault;
      prim_prev_reg <= primary_reset_n;
      sec_prev_reg <= secondary_reset_n;
      diag_prev_reg <= diag_fault_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb
  begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr == OFF_CTRL)
    begin
      rd_word = {30'h0, ctrl_reg};
    end
    else if (s_axi_araddr == OFF_WINDOW)
    begin
      rd_word = window_reg;
    end
    else if (s_axi_araddr == OFF_FAULT)
    begin
      rd_word = {24'h0, fault_reg};
    end
    else if (s_axi_araddr == OFF_STATUS)
    begin
      rd_word = {20'h0, sel_off, fast_cnt_reg, rst_cnt_reg, 1'b0, state_reg};
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_hs)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : wwrs_supervisor
`default_nettype wire

// >>> wwrs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module wwrs_checker
  import wwrs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic watchdog_select_pin,
  input wire logic main_regulator_ok,
  input wire logic osc_freq_fault,
  input wire logic primary_reset_sense,
  input wire logic diag_sense,
  input wire logic primary_reset_n,
  input wire logic secondary_reset_n,
  input wire logic diag_fault_n,
  input wire logic supplies_off
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
  a_osc_latch: assert property (osc_freq_fault |-> ##[1:3] (supplies_off
    && !primary_reset_n && !secondary_reset_n && !diag_fault_n)) else $error("osc not latched");
  a_supply_stick: assert property (supplies_off |=> supplies_off)
    else $error("supplies off dropped");
  a_reg_drop: assert property (!main_regulator_ok |-> ##[1:3] (!primary_reset_n
    && !secondary_reset_n && !diag_fault_n)) else $error("drop not seen");
  // a short dip must still hold primary low for at least 8 cycles
  a_por_hold: assert property ($fell(primary_reset_n) |=> !primary_reset_n[*8])
    else $error("primary low too short");
  a_prim_rise: assert property ($rose(primary_reset_n) |-> $past(main_regulator_ok, 8))
    else $error("primary released early");
  a_select_off: assert property (watchdog_select_pin[*5] |-> !secondary_reset_n)
    else $error("secondary high while off");
  a_rst_mismatch: assert property ((primary_reset_n != primary_reset_sense)[*3]
    |-> ##[0:3] (!diag_fault_n && !primary_reset_n)) else $error("reset mismatch missed");
  // the drive falls within a cycle, so one mismatching sample is all there is to see
  a_diag_mismatch: assert property ((diag_fault_n && !diag_sense)
    |-> ##[1:3] !diag_fault_n) else $error("diag mismatch missed");
  a_diag_rise: assert property ($rose(diag_fault_n) |-> main_regulator_ok
    && !osc_freq_fault) else $error("diag high with fault");
endmodule : wwrs_checker
bind wwrs_supervisor wwrs_checker #(.TICK_CYCLES(TICK_CYCLES)) wwrs_checker_inst (
  .clock(clock), .rst_n(rst_n), .watchdog_select_pin(watchdog_select_pin),
  .main_regulator_ok(main_regulator_ok), .osc_freq_fault(osc_freq_fault),
  .primary_reset_sense(primary_reset_sense), .diag_sense(diag_sense),
  .primary_reset_n(primary_reset_n), .secondary_reset_n(secondary_reset_n),
  .diag_fault_n(diag_fault_n), .supplies_off(supplies_off));
`default_nettype wire

// >>> wwrs_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module wwrs_mcu_model
(
  input wire logic clock,
  input wire logic en,
  input wire logic [7:0] period,
  output logic pulse
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  // wraps at the programmed period; a short period makes too-fast clears
  assign cnt_next = (!en || cnt_reg >= period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
  always_ff @(posedge clock)
  begin
    cnt_reg <= cnt_next;
  end
  // pin idles low while the processor is silent
  assign pulse = en && (cnt_reg < 8'h06);
endmodule : wwrs_mcu_model
`default_nettype wire

// >>> wwrs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_reset_supervisor_tb;
  import wwrs_pkg::*;
  logic clock = 0, rst_n = 0, clr, sel = 0, reg_ok = 1, osc = 0, brk_p = 0, brk_d = 0;
  logic mcu_en = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] period = 8'h64;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdv;
  logic prn, srn, dfn, soff, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0, n_tests = 0, k;
  always #2 clock = ~clock;
  wwrs_supervisor #(.TICK_CYCLES(4)) wwrs_supervisor_inst (.clock(clock), .rst_n(rst_n),
    .watchdog_clear_pulse_in(clr), .watchdog_select_pin(sel), .main_regulator_ok(reg_ok),
    .osc_freq_fault(osc), .primary_reset_sense(prn ^ brk_p), .secondary_reset_sense(srn),
    .diag_sense(dfn ^ brk_d), .primary_reset_n(prn), .secondary_reset_n(srn),
    .diag_fault_n(dfn), .supplies_off(soff), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wwrs_mcu_model wwrs_mcu_model_inst (.clock(clock), .en(mcu_en), .period(period), .pulse(clr));
////////////////////////////////////////////////////////////////////////////////
  task chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rready <= 1'b0;
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    for (k = 0; k < 200 && prn !== 1'b1; k++) @(posedge clock);
  endtask : do_reset
////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    chk(k >= 36 && prn === 1'b1, "power-on delay");
    rd(OFF_CTRL);
    chk(rdv === 32'h1 && rresp === RESP_OKAY, "ctrl reset value");
    rd(4'h2);
    chk(rdv === 32'h0 && rresp === RESP_SLVERR, "unmapped read refused");
    rd(OFF_WINDOW);
    chk(rdv === WINDOW_RST, "window reset value");
    wr(OFF_STATUS, 32'hffff);
    chk(bresp === RESP_OKAY, "status write resp");
  endtask : t_regs
  task t_start_fast;
    mcu_en <= 1'b1;
    for (k = 0; k < 2000 && srn !== 1'b1; k++) @(posedge clock);
    rd(OFF_STATUS);
    chk(srn === 1'b1 && rdv[2:0] === 3'h4, "monitoring started");
    wr(OFF_CTRL, 32'h0);
    period <= 8'h0c;
    cyc(400);
    chk(srn === 1'b1, "fast check disabled");
    period <= 8'h64;
    cyc(150);
    wr(OFF_CTRL, 32'h1);
    period <= 8'h0c;
    for (k = 0; k < 600 && srn !== 1'b0; k++) @(posedge clock);
    chk(k >= 100 && prn === 1'b0 && dfn === 1'b0, "ten fast clears");
    rd(OFF_FAULT);
    chk(rdv[FLT_FAST] === 1'b1, "fast fault recorded");
    period <= 8'h64;
    for (k = 0; k < 2500 && srn !== 1'b1; k++) @(posedge clock);
    wr(OFF_FAULT, 32'hff);
    cyc(4);
    chk(srn === 1'b1 && dfn === 1'b1, "recovered after clear");
  endtask : t_start_fast
  task t_slow_latch;
    mcu_en <= 1'b0;
    for (k = 0; k < 800 && srn !== 1'b0; k++) @(posedge clock);
    chk(k >= 290 && prn === 1'b0, "slow timeout");
    rd(OFF_FAULT);
    chk(rdv[FLT_SLOW] === 1'b1, "slow fault recorded");
    cyc(7000);
    rd(OFF_STATUS);
    chk(rdv[2:0] === 3'h6 && rdv[6:4] === 3'h5 && prn === 1'b0, "five resets latch");
  endtask : t_slow_latch
  task t_select;
    mcu_en <= 1'b1;
    for (k = 0; k < 2000 && srn !== 1'b1; k++) @(posedge clock);
    chk(srn === 1'b1, "running before select");
    // processor falls silent too, so a start wait would time out here
    sel <= 1'b1;
    mcu_en <= 1'b0;
    cyc(3);
    chk(srn === 1'b0, "select drops secondary");
    cyc(1200);
    rd(OFF_STATUS);
    chk(srn === 1'b0 && rdv[2:0] === 3'h1, "select disables");
    rd(OFF_FAULT);
    chk(rdv[FLT_START] === 1'b0, "no start wait");
    sel <= 1'b0;
    mcu_en <= 1'b1;
    for (k = 0; k < 2000 && srn !== 1'b1; k++) @(posedge clock);
    wr(OFF_FAULT, 32'hff);
  endtask : t_select
  task t_reg_drop;
    reg_ok <= 1'b0;
    cyc(2);
    reg_ok <= 1'b1;
    cyc(3);
    chk(prn === 1'b0 && srn === 1'b0, "drop pulls resets");
    for (k = 0; k < 200 && prn !== 1'b1; k++) @(posedge clock);
    chk(k >= 34 && prn === 1'b1, "full delay after dip");
    rd(OFF_FAULT);
    chk(rdv[FLT_REG_LOW] === 1'b1 && dfn === 1'b0, "drop recorded");
    wr(OFF_FAULT, 32'hff);
    cyc(4);
    chk(dfn === 1'b1, "diag back high");
  endtask : t_reg_drop
  task t_mismatch;
    brk_p <= 1'b1;
    cyc(8);
    rd(OFF_FAULT);
    chk(rdv[FLT_RST_MIS] === 1'b1 && dfn === 1'b0 && prn === 1'b0, "reset pin");
    brk_p <= 1'b0;
    wr(OFF_FAULT, 32'hff);
    cyc(4);
    brk_d <= 1'b1;
    cyc(8);
    rd(OFF_FAULT);
    chk(rdv[FLT_DIAG_MIS] === 1'b1 && dfn === 1'b0, "diag pin");
    brk_d <= 1'b0;
  endtask : t_mismatch
  task t_osc;
    osc <= 1'b1;
    cyc(4);
    osc <= 1'b0;
    cyc(4);
    rd(OFF_FAULT);
    chk(soff === 1'b1 && prn === 1'b0 && srn === 1'b0 && rdv[FLT_OSC] === 1'b1, "osc");
  endtask : t_osc
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    t_regs();
    t_start_fast();
    t_slow_latch();
    do_reset();
    t_select();
    t_reg_drop();
    t_mismatch();
    t_osc();
    tally_and_finish();
  end
  // run needs about 10k cycles; this leaves generous slack
  initial
  begin
    repeat (40000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
endmodule : window_watchdog_reset_supervisor_tb
`default_nettype wire
